// [rtl/nscr_regs.vh]
/*
 * Constants of the nibble stack core register file: bus offsets,
 * micro-operation codes, flag positions, vectors and reset values.
 * Assumes inclusion by the core module, its bound checker and the bench.
 */
`ifndef NSCR_REGS_VH
`define NSCR_REGS_VH
// ==========================================================
// Bus offsets
`define NSCR_OFF_FETCH   8'h00
`define NSCR_OFF_OSP     8'h04
`define NSCR_OFF_RETP    8'h08
`define NSCR_OFF_PONE    8'h0c
`define NSCR_OFF_PTWO    8'h10
`define NSCR_OFF_ACC     8'h14
`define NSCR_OFF_FLAGS   8'h18
`define NSCR_OFF_EVENTS  8'h1c
`define NSCR_RESP_OKAY   2'h0
`define NSCR_RESP_SLVERR 2'h2
// ==========================================================
// Flag positions and reset values
`define NSCR_F_WRAP      3
`define NSCR_F_JUMP      2
`define NSCR_F_GATE      0
`define NSCR_FLAGS_MASK  4'hd
`define NSCR_RST_FETCH   12'h000
`define NSCR_RST_PTR     8'h00
`define NSCR_RST_NIB     4'h0
`define NSCR_RET_STEP    8'h04
`define NSCR_ZPAGE_MASK  12'h1ff
// ==========================================================
// Pointer access modes
`define NSCR_PM_PLAIN    2'h0
`define NSCR_PM_PREINC   2'h1
`define NSCR_PM_POSTDEC  2'h2
// ==========================================================
// Micro-operation codes
`define NSCR_OP_SEQ      5'h00
`define NSCR_OP_JMP      5'h01
`define NSCR_OP_CBR      5'h02
`define NSCR_OP_CALL     5'h03
`define NSCR_OP_ZCALL    5'h04
`define NSCR_OP_RET      5'h05
`define NSCR_OP_RTI      5'h06
`define NSCR_OP_LIT      5'h07
`define NSCR_OP_DROP     5'h08
`define NSCR_OP_ALU2     5'h09
`define NSCR_OP_ALU1     5'h0a
`define NSCR_OP_FETCH    5'h0b
`define NSCR_OP_STORE    5'h0c
`define NSCR_OP_TORET    5'h0d
`define NSCR_OP_FROMRET  5'h0e
`define NSCR_OP_TBLADR   5'h0f
`define NSCR_OP_TBLDAT   5'h10
`define NSCR_OP_SETJW    5'h11
`define NSCR_OP_FLIPJ    5'h12
`define NSCR_OP_FLAGST   5'h13
`define NSCR_OP_MASK     5'h14
`define NSCR_OP_UNMASK   5'h15
`define NSCR_OP_SLEEP    5'h16
`define NSCR_OP_IN       5'h17
`define NSCR_OP_OUT      5'h18
// ==========================================================
// Event vectors, lowest level first
`define NSCR_VEC0        12'h040
`define NSCR_VEC1        12'h080
`define NSCR_VEC2        12'h0c0
`define NSCR_VEC3        12'h100
`define NSCR_VEC4        12'h140
`define NSCR_VEC5        12'h180
`define NSCR_VEC6        12'h1c0
`define NSCR_VEC7        12'h1e0
`endif

// [rtl/nscr_core_regs.v]
/*
 * Programmer-visible state of the 4-bit stack core: fetch pointer,
 * four RAM pointers, 256-nibble RAM, accumulator, flags and the
 * eight-level event controller, plus an AXI4-Lite register slave.
 * Assumes an outside decoder drives one micro-operation per
 * machine cycle and that program ROM answers in the same cycle.
 */
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "nscr_regs.vh"
`default_nettype none
module nscr_core_regs (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [4:0]  op_code,
    input  wire        op_valid,
    output wire        op_ready,
    input  wire [11:0] op_target,
    input  wire [3:0]  op_lit,
    input  wire        op_ptr_sel,
    input  wire [1:0]  op_ptr_mode,
    input  wire [3:0]  alu_result,
    input  wire        alu_carry,
    input  wire        alu_jump,
    input  wire        alu_upd_wrap,
    input  wire [7:0]  rom_data,
    input  wire        self_test_mode,
    input  wire [3:0]  io_rd_data,
    input  wire [7:0]  irq_req,
    output wire [11:0] fetch_pointer,
    output reg         rom_test_region,
    output wire [3:0]  accumulator_top,
    output reg  [3:0]  second_operand_slot,
    output wire [3:0]  flag_register,
    output reg  [3:0]  io_wr_data,
    output reg         io_wr,
    output reg         event_ack
);
// ==========================================================
// State
reg  [11:0] pc;
reg  [7:0]  osp;
reg  [7:0]  retp;
reg  [7:0]  pone;
reg  [7:0]  ptwo;
reg  [3:0]  acc;
reg  [3:0]  flags;
reg  [11:0] tbl_ret;
reg  [7:0]  pend;
reg  [7:0]  act;
reg         phase;
reg  [3:0]  ram [0:255];
reg  [11:0] next_pc;
reg  [7:0]  next_osp;
reg  [7:0]  next_retp;
reg  [7:0]  next_pone;
reg  [7:0]  next_ptwo;
reg  [3:0]  next_acc;
reg  [3:0]  next_flags;
reg  [11:0] next_tbl;
reg  [7:0]  next_pend;
reg  [7:0]  next_act;
reg         next_iowr;
reg  [2:0]  we;
reg  [7:0]  wa0;
reg  [7:0]  wa1;
reg  [7:0]  wa2;
reg  [3:0]  wd0;
reg  [3:0]  wd1;
reg  [3:0]  wd2;
reg  [7:0]  ptr;
reg  [7:0]  ptr_addr;
reg  [7:0]  ptr_next;
reg         aw_hold;
reg  [7:0]  aw_addr;
reg         w_hold;
reg  [31:0] w_data;
reg  [3:0]  w_strb;
reg  [31:0] next_rdata;
reg         rd_hit;
reg         wr_hit;
wire        take;
wire        io_op;
wire        ev_go;
wire [3:0]  ev_pick;
wire [3:0]  ev_top;
wire [3:0]  ev_done;
wire [7:0]  osp_up;
wire [7:0]  retp_up;
wire        wr_go;
wire [31:0] wm;
// ==========================================================
// Helpers
function [3:0] nscr_top;
    input [7:0] v;
    integer k;
    begin
        nscr_top = 4'h0;
        for (k = 0; k < 8; k = k + 1) begin
            if (v[k]) begin
                nscr_top = {1'b1, k[2:0]};
            end
        end
    end
endfunction
function [11:0] nscr_vec;
    input [2:0] lvl;
    begin
        case (lvl)
            3'h0: nscr_vec = `NSCR_VEC0;
            3'h1: nscr_vec = `NSCR_VEC1;
            3'h2: nscr_vec = `NSCR_VEC2;
            3'h3: nscr_vec = `NSCR_VEC3;
            3'h4: nscr_vec = `NSCR_VEC4;
            3'h5: nscr_vec = `NSCR_VEC5;
            3'h6: nscr_vec = `NSCR_VEC6;
            default: nscr_vec = `NSCR_VEC7;
        endcase
    end
endfunction
function [31:0] nscr_merge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0]  strb;
    integer k;
    begin
        for (k = 0; k < 4; k = k + 1) begin
            nscr_merge[k*8 +: 8] = strb[k] ? dat[k*8 +: 8] : old[k*8 +: 8];
        end
    end
endfunction
// ==========================================================
// Machine cycle and event priority
// Work is taken only on the second tick of each machine cycle.
assign op_ready = phase;
assign take = op_valid & phase;
assign io_op = (op_code == `NSCR_OP_IN) | (op_code == `NSCR_OP_OUT);
assign ev_pick = nscr_top(pend & ~act);
assign ev_top = nscr_top(act);
assign ev_done = ev_top;
// A level enters only above every level already in service.
assign ev_go = take & flags[`NSCR_F_GATE] & ev_pick[3]
             & (~ev_top[3] | (ev_pick[2:0] > ev_top[2:0]));
assign osp_up = osp + 8'h01;
assign retp_up = retp + `NSCR_RET_STEP;
assign fetch_pointer = pc;
assign accumulator_top = acc;
assign flag_register = flags;
// ==========================================================
// Micro-operation execution
always @* begin
    next_pc = pc;
    next_osp = osp;
    next_retp = retp;
    next_pone = pone;
    next_ptwo = ptwo;
    next_acc = acc;
    next_flags = flags;
    next_tbl = tbl_ret;
    next_act = act;
    next_iowr = 1'b0;
    we = 3'h0;
    wa0 = osp_up;
    wa1 = retp_up - 8'h01;
    wa2 = retp_up - 8'h02;
    wd0 = acc;
    wd1 = pc[7:4];
    wd2 = pc[11:8];
    // Requests are not logged on the tick that takes an I/O op.
    next_pend = pend | ((take & io_op) ? 8'h00 : irq_req);
    ptr = op_ptr_sel ? ptwo : pone;
    ptr_addr = ptr;
    ptr_next = ptr;
    case (op_ptr_mode)
        `NSCR_PM_PREINC: begin
            ptr_addr = ptr + 8'h01;
            ptr_next = ptr + 8'h01;
        end
        `NSCR_PM_POSTDEC: begin
            ptr_next = ptr - 8'h01;
        end
        default: begin
            ptr_next = ptr;
        end
    endcase
    if (ev_go) begin
        // The interrupted address is kept, not incremented.
        we = 3'h7;
        wa0 = retp_up;
        wd0 = pc[3:0];
        next_retp = retp_up;
        next_pc = nscr_vec(ev_pick[2:0]);
        next_act = act | (8'h01 << ev_pick[2:0]);
    end else if (take) begin
        next_pc = pc + 12'h001;
        case (op_code)
            `NSCR_OP_SEQ: begin
                next_pc = pc + 12'h001;
            end
            `NSCR_OP_JMP: begin
                next_pc = op_target;
            end
            `NSCR_OP_CBR: begin
                if (flags[`NSCR_F_JUMP]) begin
                    next_pc = op_target;
                end
            end
            `NSCR_OP_CALL, `NSCR_OP_ZCALL: begin
                we = 3'h7;
                wa0 = retp_up;
                wd0 = next_pc[3:0];
                wd1 = next_pc[7:4];
                wd2 = next_pc[11:8];
                next_retp = retp_up;
                next_pc = (op_code == `NSCR_OP_ZCALL)
                        ? (op_target & `NSCR_ZPAGE_MASK) : op_target;
            end
            `NSCR_OP_RET, `NSCR_OP_RTI: begin
                next_pc = {ram[retp - 8'h02], ram[retp - 8'h01], ram[retp]};
                next_retp = retp - `NSCR_RET_STEP;
                if ((op_code == `NSCR_OP_RTI) && ev_done[3]) begin
                    next_act = act & ~(8'h01 << ev_done[2:0]);
                    next_pend = next_pend & ~(8'h01 << ev_done[2:0]);
                end
            end
            `NSCR_OP_LIT, `NSCR_OP_IN: begin
                we = 3'h1;
                next_osp = osp_up;
                next_acc = (op_code == `NSCR_OP_IN) ? io_rd_data : op_lit;
            end
            `NSCR_OP_DROP, `NSCR_OP_OUT, `NSCR_OP_FLAGST: begin
                next_acc = ram[osp];
                next_osp = osp - 8'h01;
                next_iowr = (op_code == `NSCR_OP_OUT);
                if (op_code == `NSCR_OP_FLAGST) begin
                    next_flags = acc & `NSCR_FLAGS_MASK;
                end
            end
            `NSCR_OP_ALU2, `NSCR_OP_ALU1: begin
                next_acc = alu_result;
                if (op_code == `NSCR_OP_ALU2) begin
                    next_osp = osp - 8'h01;
                end
                next_flags[`NSCR_F_JUMP] = alu_jump;
                if (alu_upd_wrap) begin
                    next_flags[`NSCR_F_WRAP] = alu_carry;
                end
            end
            `NSCR_OP_FETCH: begin
                we = 3'h1;
                next_osp = osp_up;
                next_acc = ram[ptr_addr];
                if (op_ptr_sel) begin
                    next_ptwo = ptr_next;
                end else begin
                    next_pone = ptr_next;
                end
            end
            `NSCR_OP_STORE: begin
                we = 3'h1;
                wa0 = ptr_addr;
                if (op_ptr_sel) begin
                    next_ptwo = ptr_next;
                end else begin
                    next_pone = ptr_next;
                end
            end
            `NSCR_OP_TORET: begin
                // Only the low nibble of the new element is written.
                we = 3'h1;
                wa0 = retp_up;
                next_retp = retp_up;
                next_acc = ram[osp];
                next_osp = osp - 8'h01;
            end
            `NSCR_OP_FROMRET: begin
                we = 3'h1;
                next_osp = osp_up;
                next_acc = ram[retp];
                next_retp = retp - `NSCR_RET_STEP;
            end
            `NSCR_OP_TBLADR: begin
                next_tbl = pc + 12'h001;
                next_pc = op_target;
            end
            `NSCR_OP_TBLDAT: begin
                we = 3'h3;
                wa1 = osp + 8'h02;
                wd1 = rom_data[7:4];
                next_osp = osp + 8'h02;
                next_acc = rom_data[3:0];
                next_pc = tbl_ret;
            end
            `NSCR_OP_SETJW: begin
                next_flags[`NSCR_F_JUMP] = 1'b1;
                next_flags[`NSCR_F_WRAP] = 1'b1;
            end
            `NSCR_OP_FLIPJ: begin
                next_flags[`NSCR_F_JUMP] = ~flags[`NSCR_F_JUMP];
            end
            `NSCR_OP_MASK: begin
                next_flags[`NSCR_F_GATE] = 1'b0;
            end
            `NSCR_OP_UNMASK, `NSCR_OP_SLEEP: begin
                next_flags[`NSCR_F_GATE] = 1'b1;
            end
            default: begin
                next_pc = pc + 12'h001;
            end
        endcase
    end
    // A software write in the same cycle overrides the core update.
    if (wr_go) begin
        case (aw_addr)
            `NSCR_OFF_FETCH: next_pc = wm[11:0];
            `NSCR_OFF_OSP: next_osp = wm[7:0];
            `NSCR_OFF_RETP: next_retp = wm[7:0];
            `NSCR_OFF_PONE: next_pone = wm[7:0];
            `NSCR_OFF_PTWO: next_ptwo = wm[7:0];
            `NSCR_OFF_ACC: next_acc = wm[3:0];
            `NSCR_OFF_FLAGS: next_flags = wm[3:0] & `NSCR_FLAGS_MASK;
            default: next_acc = next_acc;
        endcase
    end
end
// ==========================================================
// State registers and RAM
always @(posedge aclk) begin
    if (!aresetn) begin
        pc <= `NSCR_RST_FETCH;
        osp <= `NSCR_RST_PTR;
        retp <= `NSCR_RST_PTR;
        pone <= `NSCR_RST_PTR;
        ptwo <= `NSCR_RST_PTR;
        acc <= `NSCR_RST_NIB;
        flags <= `NSCR_RST_NIB;
        tbl_ret <= `NSCR_RST_FETCH;
        pend <= 8'h00;
        act <= 8'h00;
        phase <= 1'b0;
        io_wr <= 1'b0;
        io_wr_data <= `NSCR_RST_NIB;
        event_ack <= 1'b0;
        second_operand_slot <= `NSCR_RST_NIB;
        rom_test_region <= 1'b0;
    end else begin
        pc <= next_pc;
        osp <= next_osp;
        retp <= next_retp;
        pone <= next_pone;
        ptwo <= next_ptwo;
        acc <= next_acc;
        flags <= next_flags;
        tbl_ret <= next_tbl;
        pend <= next_pend;
        act <= next_act;
        phase <= ~phase;
        io_wr <= next_iowr;
        io_wr_data <= acc;
        event_ack <= ev_go;
        second_operand_slot <= ram[next_osp];
        rom_test_region <= self_test_mode;
    end
end
always @(posedge aclk) begin
    if (we[0]) begin
        ram[wa0] <= wd0;
    end
    if (we[1]) begin
        ram[wa1] <= wd1;
    end
    if (we[2]) begin
        ram[wa2] <= wd2;
    end
end
// ==========================================================
// AXI4-Lite slave
// Address and data may arrive in either order; each is parked.
assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
assign s_axi_wready = ~w_hold & ~s_axi_bvalid;
assign s_axi_arready = ~s_axi_rvalid;
assign wr_go = aw_hold & w_hold;
always @* begin
    next_rdata = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
        `NSCR_OFF_FETCH: next_rdata = {20'h00000, pc};
        `NSCR_OFF_OSP: next_rdata = {24'h000000, osp};
        `NSCR_OFF_RETP: next_rdata = {24'h000000, retp};
        `NSCR_OFF_PONE: next_rdata = {24'h000000, pone};
        `NSCR_OFF_PTWO: next_rdata = {24'h000000, ptwo};
        `NSCR_OFF_ACC: next_rdata = {28'h0000000, acc};
        `NSCR_OFF_FLAGS: next_rdata = {28'h0000000, flags};
        `NSCR_OFF_EVENTS: next_rdata = {16'h0000, act, pend};
        default: rd_hit = 1'b0;
    endcase
    wr_hit = (aw_addr <= `NSCR_OFF_FLAGS) && (aw_addr[1:0] == 2'h0);
end
assign wm = nscr_merge({20'h00000, (aw_addr == `NSCR_OFF_FETCH) ? pc : 12'h000},
                       w_data, w_strb);
always @(posedge aclk) begin
    if (!aresetn) begin
        aw_hold <= 1'b0;
        aw_addr <= 8'h00;
        w_hold <= 1'b0;
        w_data <= 32'h0000_0000;
        w_strb <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `NSCR_RESP_OKAY;
        s_axi_rvalid <= 1'b0;
        s_axi_rresp <= `NSCR_RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
        if (wr_go) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `NSCR_RESP_OKAY : `NSCR_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= rd_hit ? `NSCR_RESP_OKAY : `NSCR_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end
endmodule
`default_nettype wire

// [testbench/nscr_core_regs_properties.sv]
/*
 * Checker for the nibble stack core registers: bus handshakes and
 * micro-operation effects. Assumes the core's ports and header macros.
 */
`timescale 1ns/1ps
`default_nettype none
`include "nscr_regs.vh"
module nscr_core_regs_properties (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [4:0]  op_code,
    input wire logic        op_valid,
    input wire logic        op_ready,
    input wire logic [11:0] op_target,
    input wire logic [3:0]  op_lit,
    input wire logic        alu_upd_wrap,
    input wire logic        self_test_mode,
    input wire logic [11:0] fetch_pointer,
    input wire logic        rom_test_region,
    input wire logic [3:0]  accumulator_top,
    input wire logic [3:0]  flag_register,
    input wire logic        event_ack
);
    // ==========================================================
    // Properties
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // An op offered with the gate open may be swapped for an event call.
    wire tk = op_valid && op_ready && !flag_register[0];
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped or changed");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped or changed");
    a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while answer pending");
    a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_cycle_phase: assert property (op_ready |=> !op_ready ##1 op_ready)
        else $error("machine cycle is not two clocks");
    a_seq_step: assert property (tk && op_code == `NSCR_OP_SEQ |=> fetch_pointer == $past(fetch_pointer) + 12'h001)
        else $error("fetch pointer did not step");
    a_jump_load: assert property (tk && op_code == `NSCR_OP_JMP |=> fetch_pointer == $past(op_target))
        else $error("jump target not loaded");
    a_branch_cond: assert property (tk && op_code == `NSCR_OP_CBR |=> fetch_pointer == ($past(flag_register[2]) ? $past(op_target) : $past(fetch_pointer) + 12'h001))
        else $error("conditional branch wrong");
    a_lit_load: assert property (tk && op_code == `NSCR_OP_LIT |=> accumulator_top == $past(op_lit))
        else $error("literal not in accumulator");
    a_bool_wrap: assert property (tk && op_code == `NSCR_OP_ALU2 && !alu_upd_wrap |=> $stable(flag_register[3]))
        else $error("boolean op changed wrap flag");
    a_mask_gate: assert property (tk && op_code == `NSCR_OP_MASK |=> !flag_register[0])
        else $error("mask left gate open");
    a_test_region: assert property (rom_test_region == $past(self_test_mode))
        else $error("test region flag lags wrongly");
    a_mask_close: assert property (op_valid && op_ready && op_code == `NSCR_OP_MASK |=> event_ack || !flag_register[0])
        else $error("mask op left gate open");
    a_event_vec: assert property (event_ack |-> fetch_pointer[4:0] == 5'h00 && fetch_pointer[11:9] == 3'h0)
        else $error("event call missed zero page vector");
endmodule
bind nscr_core_regs nscr_core_regs_properties props (.*);
`default_nettype wire

// [testbench/tb.sv]
/*
 * Self-checking bench for the nibble stack core registers.
 * Assumes the core module, its header and the bound checker.
 */
`timescale 1ns/1ps
`default_nettype none
`include "nscr_regs.vh"
module tb;
    // ==========================================================
    // Signals
    reg aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    reg s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, op_valid = 1'h0, op_ptr_sel = 1'h0;
    reg alu_carry = 1'h0, alu_jump = 1'h0, alu_upd_wrap = 1'h0, self_test_mode = 1'h0;
    reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rom_data = 8'h00, irq_req = 8'h00, i;
    reg [31:0] s_axi_wdata = 32'h0;
    reg [3:0] s_axi_wstrb = 4'hf, op_lit = 4'h0, alu_result = 4'h0, io_rd_data = 4'h0;
    reg [4:0] op_code = 5'h00;
    reg [11:0] op_target = 12'h000;
    reg [1:0] op_ptr_mode = 2'h0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, op_ready;
    wire rom_test_region, io_wr, event_ack;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [11:0] fetch_pointer;
    wire [3:0] accumulator_top, second_operand_slot, flag_register, io_wr_data;
    integer fails = 0, checks = 0, cyc = 0;
    nscr_core_regs uut (.*);
    always #5 aclk = ~aclk;
    // ==========================================================
    // Tasks
    task test_done;
        begin
            if (fails == 0 && checks > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    task chk(input string n, input [31:0] g, input [31:0] e);
        begin
            checks = checks + 1;
            if (g !== e) begin
                fails = fails + 1;
                $display("[ERR] %s expected %h seen %h", n, e, g);
            end
        end
    endtask
    // Handshakes are judged at the falling edge, where everything is settled.
    task wr(input [7:0] a, input [31:0] d, input [1:0] er);
        reg ta, tw, b;
        reg [1:0] r;
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'h1;
            s_axi_wvalid <= 1'h1;
            s_axi_bready <= 1'h1;
            b = 1'h0;
            while (!b) begin
                @(negedge aclk);
                ta = s_axi_awvalid & s_axi_awready;
                tw = s_axi_wvalid & s_axi_wready;
                b = s_axi_bvalid;
                r = s_axi_bresp;
                @(posedge aclk);
                if (ta) s_axi_awvalid <= 1'h0;
                if (tw) s_axi_wvalid <= 1'h0;
            end
            s_axi_bready <= 1'h0;
            @(posedge aclk);
            chk($sformatf("bresp %h", a), r, er);
        end
    endtask
    task rd(input [7:0] a, input [31:0] e, input [1:0] er);
        reg ta, t;
        reg [31:0] d;
        reg [1:0] r;
        begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'h1;
            s_axi_rready <= 1'h1;
            t = 1'h0;
            while (!t) begin
                @(negedge aclk);
                ta = s_axi_arvalid & s_axi_arready;
                t = s_axi_rvalid;
                d = s_axi_rdata;
                r = s_axi_rresp;
                @(posedge aclk);
                if (ta) s_axi_arvalid <= 1'h0;
            end
            s_axi_rready <= 1'h0;
            @(posedge aclk);
            chk($sformatf("reg %h", a), d, e);
            chk($sformatf("rresp %h", a), r, er);
        end
    endtask
    task op(input [4:0] c, input [11:0] t, input [3:0] l);
        reg k;
        begin
            op_code <= c;
            op_target <= t;
            op_lit <= l;
            op_valid <= 1'h1;
            k = 1'h0;
            while (!k) begin
                @(negedge aclk);
                k = op_ready;
                @(posedge aclk);
            end
            op_valid <= 1'h0;
            @(posedge aclk);
            @(posedge aclk);
        end
    endtask
    // ==========================================================
    // Timeout and sequence
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            fails = fails + 1;
            test_done;
        end
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        for (i = 8'h00; i < 8'h20; i = i + 8'h04)
            rd(i, 32'h0, 2'h0);
        rd(8'h20, 32'h0, 2'h2);
        wr(8'h1c, 32'hffff, 2'h2);
        for (i = 8'h00; i < 8'h1c; i = i + 8'h04) begin
            wr(i, 32'hffffffff, 2'h0);
            rd(i, i == 8'h00 ? 32'hfff : i < 8'h14 ? 32'hff : i == 8'h14 ? 32'hf : 32'hd, 2'h0);
        end
        wr(8'h18, 32'h0, 2'h0);
        wr(8'h04, 32'h10, 2'h0);
        wr(8'h08, 32'hfc, 2'h0);
        wr(8'h00, 32'h100, 2'h0);
        self_test_mode <= 1'h1;
        op(`NSCR_OP_LIT, 12'h000, 4'h5);
        op(`NSCR_OP_LIT, 12'h000, 4'ha);
        chk("second", second_operand_slot, 32'h5);
        op(`NSCR_OP_DROP, 12'h000, 4'h0);
        chk("acc", accumulator_top, 32'h5);
        rd(8'h04, 32'h11, 2'h0);
        op(`NSCR_OP_CALL, 12'h234, 4'h0);
        rd(8'h08, 32'h00, 2'h0);
        chk("pc", fetch_pointer, 32'h234);
        op(`NSCR_OP_RET, 12'h000, 4'h0);
        chk("pc", fetch_pointer, 32'h104);
        rd(8'h08, 32'hfc, 2'h0);
        op(`NSCR_OP_ZCALL, 12'hfff, 4'h0);
        chk("pc", fetch_pointer, 32'h1ff);
        op(`NSCR_OP_CBR, 12'h3ab, 4'h0);
        op(`NSCR_OP_SETJW, 12'h000, 4'h0);
        chk("flags", flag_register, 32'hc);
        op(`NSCR_OP_FLIPJ, 12'h000, 4'h0);
        chk("flags", flag_register, 32'h8);
        op(`NSCR_OP_FLIPJ, 12'h000, 4'h0);
        op(`NSCR_OP_CBR, 12'h3ab, 4'h0);
        chk("pc", fetch_pointer, 32'h3ab);
        op(`NSCR_OP_JMP, 12'h456, 4'h0);
        op(`NSCR_OP_SEQ, 12'h000, 4'h0);
        alu_result <= 4'h3;
        alu_upd_wrap <= 1'h1;
        op(`NSCR_OP_ALU2, 12'h000, 4'h0);
        chk("acc", accumulator_top, 32'h3);
        chk("flags", flag_register, 32'h0);
        alu_carry <= 1'h1;
        alu_upd_wrap <= 1'h0;
        op(`NSCR_OP_ALU2, 12'h000, 4'h0);
        chk("flags", flag_register, 32'h0);
        wr(8'h0c, 32'h40, 2'h0);
        op_ptr_mode <= `NSCR_PM_PREINC;
        op(`NSCR_OP_STORE, 12'h000, 4'h0);
        rd(8'h0c, 32'h41, 2'h0);
        op(`NSCR_OP_LIT, 12'h000, 4'h9);
        wr(8'h10, 32'h41, 2'h0);
        op_ptr_sel <= 1'h1;
        op_ptr_mode <= `NSCR_PM_POSTDEC;
        op(`NSCR_OP_FETCH, 12'h000, 4'h0);
        chk("acc", accumulator_top, 32'h3);
        rd(8'h10, 32'h40, 2'h0);
        op(`NSCR_OP_TBLADR, 12'h555, 4'h0);
        rom_data <= 8'h6c;
        op(`NSCR_OP_TBLDAT, 12'h000, 4'h0);
        chk("acc", accumulator_top, 32'hc);
        chk("second", second_operand_slot, 32'h6);
        io_rd_data <= 4'h9;
        op(`NSCR_OP_IN, 12'h000, 4'h0);
        chk("acc", accumulator_top, 32'h9);
        op(`NSCR_OP_OUT, 12'h000, 4'h0);
        chk("out", io_wr_data, 32'hc);
        self_test_mode <= 1'h0;
        irq_req <= 8'h80;
        op(`NSCR_OP_UNMASK, 12'h000, 4'h0);
        chk("gate", flag_register[0], 32'h1);
        op(`NSCR_OP_SEQ, 12'h000, 4'h0);
        chk("pc", fetch_pointer, 32'h1e0);
        rd(8'h1c, 32'h8080, 2'h0);
        irq_req <= 8'h00;
        op(`NSCR_OP_RTI, 12'h000, 4'h0);
        chk("pc", fetch_pointer, 32'h460);
        rd(8'h1c, 32'h0, 2'h0);
        op(`NSCR_OP_MASK, 12'h000, 4'h0);
        op(`NSCR_OP_UNMASK, 12'h000, 4'h0);
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        chk("pc", fetch_pointer, 32'h0);
        chk("flags", flag_register, 32'h0);
        test_done;
    end
endmodule
`default_nettype wire
